// *** hw/memctl_regs.sv ***
// memory controller control registers behind a wishbone slave
`timescale 1ns/1ps
`include "memctl_consts.svh"
module memctl_regs (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        enhanced_mode_i,
  input  wire logic        gart_cache_enable_i,
  input  wire logic        gfx_req_read_i,
  input  wire logic        gfx_req_write_i,
  input  wire logic        gfx_req_disp_i,
  input  wire logic        nb_req_read_i,
  input  wire logic        nb_req_write_i,
  input  wire logic        nb_req_disp_i,
  input  wire logic [1:0]  pin_gfx_level_i,
  input  wire logic [1:0]  pin_nb_level_i,
  input  wire logic        blackout_req_i,
  input  wire logic [15:0] debug_bus_i,
  input  wire logic        walk_illegal_i,
  input  wire logic        walk_page_err_i,
  input  wire logic [1:0]  walk_err_source_i,
  input  wire logic        walk_op_done_i,
  output logic             gfx_accept_o,
  output logic             nb_accept_o,
  output logic [3:0]       burst_count_group_one,
  output logic [3:0]       burst_count_group_two,
  output logic             index_set_select_o,
  output logic [6:0]       debug_select_o,
  output logic             debug_enable_o,
  output logic             fifo_pop_enable_o,
  output logic             blackout_o,
  output logic             walker_halt_o,
  output logic             system_error_o,
  output logic             tlb_cache_enable_o,
  output logic             lookahead_enable_o,
  output logic             single_level_o,
  output logic             dir_cache_active_o,
  output logic [39:0]      dir_base_o,
  output logic [31:0]      fb_start_o,
  output logic             flush_all_o,
  output logic             entry_flush_o,
  output logic             entry_refresh_o,
  output logic [19:0]      entry_address_o
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic [31:0] general_reg;
  logic [31:0] misc_reg;
  logic [31:0] fb_reg;
  logic [31:0] debug_reg;
  logic [31:0] throttle_reg;
  logic [31:0] feature_reg;
  logic [31:0] dir_reg;
  logic        flush_pending;
  logic [1:0]  entry_pending;
  logic [19:0] entry_addr;
  logic        page_flag;
  logic [1:0]  page_source;
  logic [15:0] debug_sample;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] lanes, input logic [31:0] mask);
    logic [31:0] lane_m;
    lane_m = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}} & mask;
    byte_merge = (old_v & ~lane_m) | (new_v & lane_m);
  endfunction : byte_merge

  wire       req       = cyc_i && stb_i && !ack_o;
  wire       addr_ok   = (adr_i[1:0] == 2'h0);
  wire [5:0] idx       = adr_i[7:2];
  wire       wr        = req && we_i && addr_ok;
  wire       wr_gen    = wr && (idx == `IDX_GENERAL);
  wire       wr_misc   = wr && (idx == `IDX_MISC);
  wire       wr_fb     = wr && (idx == `IDX_FB_START);
  wire       wr_dbg    = wr && (idx == `IDX_DEBUG);
  wire       wr_thr    = wr && (idx == `IDX_THROTTLE);
  wire       wr_feat   = wr && (idx == `IDX_FEATURE);
  wire       wr_dir    = wr && (idx == `IDX_DIR_BASE);
  wire       wr_cache  = wr && (idx == `IDX_CACHE_CTRL) && sel_i[0];
  wire       wr_entry  = wr && (idx == `IDX_ENTRY_CTRL);

  wire [31:0] feature_view = {feature_reg[31:30], page_source, 2'h0, feature_reg[25],
                              page_flag, 5'h00, feature_reg[18:16], 4'h0, feature_reg[11],
                              3'h1, 8'h00};
  wire [31:0] debug_view = {debug_sample, debug_reg[15:0]};
  wire [31:0] entry_view = {entry_addr, 10'h000, entry_pending};

  logic [31:0] rd_mux;
  always_comb begin
    unique case (idx)
      `IDX_GENERAL:    rd_mux = general_reg;
      `IDX_MISC:       rd_mux = misc_reg;
      `IDX_FB_START:   rd_mux = fb_reg;
      `IDX_DEBUG:      rd_mux = debug_view;
      `IDX_THROTTLE:   rd_mux = throttle_reg;
      `IDX_FEATURE:    rd_mux = feature_view;
      `IDX_DIR_BASE:   rd_mux = dir_reg;
      `IDX_CACHE_SIZE: rd_mux = `CACHE_SIZE_VAL;
      `IDX_CACHE_CTRL: rd_mux = {31'h0, flush_pending};
      `IDX_ENTRY_CTRL: rd_mux = entry_view;
      default:         rd_mux = `RST_ZERO;
    endcase
  end
  wire [31:0] next_dat = (addr_ok && !we_i) ? rd_mux : `RST_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `RST_ZERO;
    end else begin
      ack_o <= req;
      dat_o <= req ? next_dat : dat_o;
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      general_reg  <= `RST_GENERAL;
      misc_reg     <= `RST_MISC;
      fb_reg       <= `RST_ZERO;
      debug_reg    <= `RST_ZERO;
      throttle_reg <= `RST_ZERO;
      feature_reg  <= `RST_ZERO;
      dir_reg      <= `RST_ZERO;
    end else begin
      if (wr_gen)  general_reg  <= byte_merge(general_reg, dat_i, sel_i, `WMASK_GENERAL);
      if (wr_misc) misc_reg     <= byte_merge(misc_reg, dat_i, sel_i, `WMASK_MISC);
      if (wr_fb)   fb_reg       <= byte_merge(fb_reg, dat_i, sel_i, `WMASK_FB);
      if (wr_dbg)  debug_reg    <= byte_merge(debug_reg, dat_i, sel_i, `WMASK_DEBUG);
      if (wr_thr)  throttle_reg <= byte_merge(throttle_reg, dat_i, sel_i, `WMASK_THROTTLE);
      if (wr_feat) feature_reg  <= byte_merge(feature_reg, dat_i, sel_i, `WMASK_FEATURE);
      if (wr_dir)  dir_reg      <= byte_merge(dir_reg, dat_i, sel_i, `WMASK_DIR_BASE);
    end
  end

  // ---------------------------------------------------------------
  // cache maintenance and error capture
  // ---------------------------------------------------------------
  wire flush_start   = wr_cache && dat_i[`B_FLUSH];
  wire entry_start_f = wr_entry && sel_i[0] && dat_i[`B_FLUSH];
  wire entry_start_r = wr_entry && sel_i[0] && dat_i[`B_REFRESH];
  wire any_pending   = flush_pending || (entry_pending != 2'h0);
  wire op_done       = walk_op_done_i && any_pending;
  wire page_event    = walk_page_err_i && feature_reg[`B_PAGE_ERR_EN];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flush_pending <= 1'b0;
      entry_pending <= 2'h0;
      entry_addr    <= 20'h00000;
    end else begin
      // a new start wins over a completion in the same cycle
      if (flush_start)  flush_pending    <= 1'b1;
      else if (op_done) flush_pending    <= 1'b0;
      if (entry_start_f) entry_pending[0] <= 1'b1;
      else if (op_done)  entry_pending[0] <= 1'b0;
      if (entry_start_r) entry_pending[1] <= 1'b1;
      else if (op_done)  entry_pending[1] <= 1'b0;
      if (wr_entry && sel_i[3] && sel_i[2] && sel_i[1]) entry_addr <= dat_i[31:12];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_flag   <= 1'b0;
      page_source <= 2'h0;
    end else if (page_event && !page_flag) begin
      page_flag   <= 1'b1;
      page_source <= walk_err_source_i;
    end
  end

  // ---------------------------------------------------------------
  // table walker state
  // ---------------------------------------------------------------
  memctl_pkg::walk_state_t walk_state;
  memctl_pkg::walk_state_t next_walk_state;
  wire hang_event = (walk_illegal_i && feature_reg[`B_HANG_EN]) || page_event;
  always_comb begin
    unique case (walk_state)
      memctl_pkg::WALK_IDLE: next_walk_state = hang_event ? memctl_pkg::WALK_HANG
                                              : any_pending ? memctl_pkg::WALK_BUSY
                                              : memctl_pkg::WALK_IDLE;
      memctl_pkg::WALK_BUSY: next_walk_state = hang_event ? memctl_pkg::WALK_HANG
                                              : op_done ? memctl_pkg::WALK_IDLE
                                              : memctl_pkg::WALK_BUSY;
      memctl_pkg::WALK_HANG: next_walk_state = memctl_pkg::WALK_HANG;
      default:               next_walk_state = memctl_pkg::WALK_IDLE;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) walk_state <= memctl_pkg::WALK_IDLE;
    else       walk_state <= next_walk_state;
  end

  // ---------------------------------------------------------------
  // debug rotation and blackout delay
  // ---------------------------------------------------------------
  logic [3:0] rot_count;
  logic [6:0] rot_select;
  wire rotate_on   = misc_reg[`B_ROTATE];
  wire rotate_step = rotate_on && (rot_count == 4'hF);
  always_ff @(posedge clk_i) begin
    if (rst_i || !rotate_on) begin
      rot_count  <= 4'h0;
      rot_select <= 7'h00;
    end else begin
      rot_count <= rot_count + 4'h1;
      if (rotate_step) rot_select <= rot_select + 7'h01;
    end
  end
  wire [6:0] next_dbg_sel = rotate_on ? rot_select : debug_reg[14:8];

  logic [2:0] black_sync;
  logic [1:0] black_dly;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      black_sync <= 3'h0;
      black_dly  <= 2'h0;
    end else begin
      black_sync <= {black_sync[1:0], blackout_req_i};
      black_dly  <= {black_dly[0], black_sync[2]};
    end
  end
  wire black_ok    = (black_sync[2] == black_sync[1]);
  wire next_black  = throttle_reg[`B_BLACK_DLY] ? black_dly[1] : black_dly[0];

  // ---------------------------------------------------------------
  // throttling
  // ---------------------------------------------------------------
  logic [`THR_PERIOD_W-1:0] thr_phase;
  always_ff @(posedge clk_i) begin
    if (rst_i) thr_phase <= 7'h00;
    else       thr_phase <= thr_phase + 7'h01;
  end
  logic gfx_block;
  logic nb_block;
  throttle_gate u_gfx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .enable_i    (throttle_reg[`B_GFX_EN]),
    .source_i    (throttle_reg[`B_GFX_SRC]),
    .reg_level_i (throttle_reg[3:2]),
    .pin_level_i (pin_gfx_level_i),
    .phase_i     (thr_phase),
    .block_o     (gfx_block)
  );
  throttle_gate u_nb (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .enable_i    (throttle_reg[`B_NB_EN]),
    .source_i    (throttle_reg[`B_NB_SRC]),
    .reg_level_i (throttle_reg[7:6]),
    .pin_level_i (pin_nb_level_i),
    .phase_i     (thr_phase),
    .block_o     (nb_block)
  );
  wire gfx_typed = (gfx_req_read_i && throttle_reg[`B_BLK_RD]) ||
                   (gfx_req_write_i && throttle_reg[`B_BLK_WR]) ||
                   (gfx_req_disp_i && throttle_reg[`B_BLK_DISP]);
  wire nb_typed  = (nb_req_read_i && throttle_reg[`B_BLK_RD]) ||
                   (nb_req_write_i && throttle_reg[`B_BLK_WR]) ||
                   (nb_req_disp_i && throttle_reg[`B_BLK_DISP]);
  wire init_ok   = general_reg[`B_INIT_DONE];
  wire next_gfx_accept = init_ok && !(gfx_block && gfx_typed);
  wire next_nb_accept  = init_ok && !(nb_block && nb_typed);

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  wire single_lvl = feature_reg[`B_SINGLE_LVL];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gfx_accept_o          <= 1'b0;
      nb_accept_o           <= 1'b0;
      burst_count_group_one <= 4'h0;
      burst_count_group_two <= 4'h0;
      index_set_select_o    <= 1'b0;
      debug_select_o        <= 7'h00;
      debug_enable_o        <= 1'b0;
      fifo_pop_enable_o     <= 1'b0;
      blackout_o            <= 1'b0;
      walker_halt_o         <= 1'b0;
      system_error_o        <= 1'b0;
      tlb_cache_enable_o    <= 1'b0;
      lookahead_enable_o    <= 1'b0;
      single_level_o        <= 1'b0;
      dir_cache_active_o    <= 1'b0;
      dir_base_o            <= 40'h0000000000;
      fb_start_o            <= `RST_ZERO;
      flush_all_o           <= 1'b0;
      entry_flush_o         <= 1'b0;
      entry_refresh_o       <= 1'b0;
      entry_address_o       <= 20'h00000;
      debug_sample          <= 16'h0000;
    end else begin
      gfx_accept_o          <= next_gfx_accept;
      nb_accept_o           <= next_nb_accept;
      burst_count_group_one <= general_reg[3:0];
      burst_count_group_two <= general_reg[7:4];
      if (!enhanced_mode_i) index_set_select_o <= misc_reg[`B_INDEX_SEL];
      debug_select_o        <= next_dbg_sel;
      debug_enable_o        <= debug_reg[`B_DBG_EN];
      fifo_pop_enable_o     <= !debug_reg[`B_RS_STALL];
      if (black_ok) blackout_o <= next_black;
      walker_halt_o         <= (next_walk_state == memctl_pkg::WALK_HANG);
      system_error_o        <= system_error_o || page_event;
      tlb_cache_enable_o    <= feature_reg[`B_TLB_EN];
      lookahead_enable_o    <= feature_reg[`B_LOOKAHEAD];
      single_level_o        <= single_lvl;
      dir_cache_active_o    <= !single_lvl && feature_reg[`B_DIR_CACHE]
                               && gart_cache_enable_i;
      dir_base_o            <= {dir_reg[11:4], dir_reg[31:12], 12'h000};
      fb_start_o            <= fb_reg;
      flush_all_o           <= flush_pending;
      entry_flush_o         <= entry_pending[0];
      entry_refresh_o       <= entry_pending[1];
      entry_address_o       <= entry_addr;
      debug_sample          <= debug_bus_i;
    end
  end
endmodule : memctl_regs

// *** pkg/memctl_consts.svh ***
// register offsets, field positions and timing constants of the memory controller block
`ifndef MEMCTL_CONSTS_SVH
`define MEMCTL_CONSTS_SVH
// register indices (byte address = 4 * index)
`define IDX_GENERAL     6'h00
`define IDX_MISC        6'h18
`define IDX_FB_START    6'h1E
`define IDX_DEBUG       6'h1F
`define IDX_THROTTLE    6'h26
`define IDX_FEATURE     6'h2B
`define IDX_DIR_BASE    6'h2C
`define IDX_CACHE_SIZE  6'h2D
`define IDX_CACHE_CTRL  6'h2E
`define IDX_ENTRY_CTRL  6'h2F
// reset values and the fixed cache size read value
`define RST_GENERAL     32'h00000300
`define RST_MISC        32'h00004000
`define RST_ZERO        32'h00000000
`define CACHE_SIZE_VAL  32'h00000010
// writable masks
`define WMASK_GENERAL   32'h800F3FFF
`define WMASK_MISC      32'h80005006
`define WMASK_FB        32'hFFFFFFE0
`define WMASK_DEBUG     32'h0000FF1F
`define WMASK_THROTTLE  32'h00000FFF
`define WMASK_FEATURE   32'hC20F0800
`define WMASK_DIR_BASE  32'hFFFFFFF0
// field positions
`define B_INIT_DONE     31
`define B_INDEX_SEL     12
`define B_ROTATE        31
`define B_RS_STALL      3
`define B_DBG_EN        15
`define B_GFX_SRC       0
`define B_GFX_EN        1
`define B_NB_SRC        4
`define B_NB_EN         5
`define B_BLACK_DLY     8
`define B_BLK_RD        9
`define B_BLK_WR        10
`define B_BLK_DISP      11
`define B_HANG_EN       11
`define B_PAGE_ERR_EN   16
`define B_TLB_EN        18
`define B_LOOKAHEAD     25
`define B_SINGLE_LVL    30
`define B_DIR_CACHE     31
`define B_FLUSH         0
`define B_REFRESH       1
// throttle timing
`define THR_PERIOD_W    7
`define THR_BLK_64      7'h40
`define THR_BLK_96      7'h60
`define THR_BLK_112     7'h70
`endif

// *** pkg/memctl_pkg.sv ***
// types shared by the memory controller register block
package memctl_pkg;
  typedef enum logic [2:0] {
    WALK_IDLE = 3'b001,
    WALK_BUSY = 3'b010,
    WALK_HANG = 3'b100
  } walk_state_t;
  typedef logic [1:0] throttle_level_t;
endpackage : memctl_pkg

// *** hw/throttle_gate.sv ***
// one throttle path: source select, enable and blocking window decode
`timescale 1ns/1ps
`include "memctl_consts.svh"
module throttle_gate (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       enable_i,
  input  wire logic                       source_i,
  input  wire logic [1:0]                 reg_level_i,
  input  wire logic [1:0]                 pin_level_i,
  input  wire logic [`THR_PERIOD_W-1:0]   phase_i,
  output logic                            block_o
);
  function automatic logic [`THR_PERIOD_W-1:0] window_len(input logic [1:0] lvl);
    case (lvl)
      2'h1:    window_len = `THR_BLK_64;
      2'h2:    window_len = `THR_BLK_96;
      2'h3:    window_len = `THR_BLK_112;
      default: window_len = 7'h00;
    endcase
  endfunction : window_len

  wire memctl_pkg::throttle_level_t level = source_i ? pin_level_i : reg_level_i;
  wire [`THR_PERIOD_W-1:0] limit = window_len(level);
  wire next_block = enable_i && (phase_i < limit);

  always_ff @(posedge clk_i) begin
    if (rst_i) block_o <= 1'b0;
    else       block_o <= next_block;
  end
endmodule : throttle_gate

// *** bench/memctl_regs_checker.sv ***
// port assertions of the register block
`timescale 1ns/1ps
module memctl_regs_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic        gfx_accept_o,
  input wire logic        nb_accept_o,
  input wire logic        walker_halt_o,
  input wire logic        system_error_o,
  input wire logic        single_level_o,
  input wire logic        dir_cache_active_o,
  input wire logic [39:0] dir_base_o,
  input wire logic [31:0] fb_start_o,
  input wire logic        flush_all_o,
  input wire logic        walk_op_done_i
);
  logic ready_q;
  // mirror of the gate bit at its write
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ready_q <= 1'h0;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00 && sel_i[3])
      ready_q <= dat_i[31];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence gate_shut;
    !ready_q [*3];
  endsequence
  chk_ack_answer: assert property (bus_req |=> ack_o) else $error("no ack after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than a cycle");
  chk_gate_closed: assert property (
    gate_shut |-> !gfx_accept_o && !nb_accept_o) else $error("request accepted while gated");
  chk_fb_low_zero: assert property (fb_start_o[4:0] == 5'h00) else $error("fb low bits set");
  chk_dir_granule: assert property (dir_base_o[11:0] == 12'h000) else $error("dir base low bits");
  chk_dir_cache_mode: assert property (
    dir_cache_active_o |-> !single_level_o) else $error("dir cache in single level");
  chk_flush_hold: assert property (
    flush_all_o && !walk_op_done_i && !$past(walk_op_done_i) |=> flush_all_o)
    else $error("flush pending dropped early");
  chk_serr_sticky: assert property (system_error_o |=> system_error_o) else $error("serr dropped");
  chk_halt_sticky: assert property (walker_halt_o |=> walker_halt_o) else $error("halt dropped");
endmodule : memctl_regs_checker
bind memctl_regs memctl_regs_checker memctl_regs_checker_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .gfx_accept_o(gfx_accept_o),
  .nb_accept_o(nb_accept_o), .walker_halt_o(walker_halt_o), .system_error_o(system_error_o),
  .single_level_o(single_level_o), .dir_cache_active_o(dir_cache_active_o),
  .dir_base_o(dir_base_o), .fb_start_o(fb_start_o), .flush_all_o(flush_all_o),
  .walk_op_done_i(walk_op_done_i));

// *** bench/mem_clients.sv ***
// model of the memory request clients
`timescale 1ns/1ps
module mem_clients (
  input  wire logic       clk_i,
  input  wire logic       clear_i,
  input  wire logic [2:0] kind_i,
  input  wire logic       gfx_accept_i,
  input  wire logic       nb_accept_i,
  output logic            req_read_o,
  output logic            req_write_o,
  output logic            req_disp_o,
  output logic [7:0]      gfx_held_o,
  output logic [7:0]      nb_held_o
);
  assign {req_disp_o, req_write_o, req_read_o} = kind_i;
  // count cycles in which a pending request was held off
  always_ff @(posedge clk_i) begin
    if (clear_i) begin
      gfx_held_o <= 8'h00;
      nb_held_o  <= 8'h00;
    end else begin
      gfx_held_o <= gfx_held_o + {7'h00, (|kind_i) && !gfx_accept_i};
      nb_held_o  <= nb_held_o + {7'h00, (|kind_i) && !nb_accept_i};
    end
  end
endmodule : mem_clients

// *** bench/memctl_regs_bench.sv ***
// self-checking bench of the register block
`timescale 1ns/1ps
`include "memctl_consts.svh"
module memctl_regs_bench;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, clear = 1'h0;
  logic [7:0]  adr_i = 8'h00, gfx_held, nb_held, a, dl[2];
  logic [3:0]  sel_i = 4'hF, burst_count_group_one, burst_count_group_two;
  logic [31:0] dat_i = 32'h0, dat_o, rdata, r, v, seed = 32'hEF1B96F8, fb_start_o;
  logic        enhanced_mode_i = 1'h0, gart_cache_enable_i = 1'h0, blackout_req_i = 1'h0;
  logic        walk_illegal_i = 1'h0, walk_page_err_i = 1'h0, walk_op_done_i = 1'h0;
  logic        ack_o, gfx_accept_o, nb_accept_o, blackout_o, index_set_select_o, rd_q, wr_q, dp_q;
  logic        debug_enable_o, fifo_pop_enable_o, walker_halt_o, system_error_o, single_level_o;
  logic        tlb_cache_enable_o, lookahead_enable_o, dir_cache_active_o;
  logic        flush_all_o, entry_flush_o, entry_refresh_o;
  logic [1:0]  pin_gfx_level_i = 2'h0, pin_nb_level_i = 2'h0, walk_err_source_i = 2'h0, lv;
  logic [2:0]  kind = 3'h1;
  logic [6:0]  debug_select_o;
  logic [15:0] debug_bus_i = 16'h0;
  logic [19:0] entry_address_o;
  logic [39:0] dir_base_o;
  int          num_errors = 0, checked = 0, ticks = 0, n;
  memctl_regs memctl_regs_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .enhanced_mode_i(enhanced_mode_i), .gart_cache_enable_i(gart_cache_enable_i),
    .gfx_req_read_i(rd_q), .gfx_req_write_i(wr_q), .gfx_req_disp_i(dp_q), .nb_req_read_i(rd_q),
    .nb_req_write_i(wr_q), .nb_req_disp_i(dp_q), .pin_gfx_level_i(pin_gfx_level_i),
    .pin_nb_level_i(pin_nb_level_i), .blackout_req_i(blackout_req_i), .debug_bus_i(debug_bus_i),
    .walk_illegal_i(walk_illegal_i), .walk_page_err_i(walk_page_err_i),
    .walk_err_source_i(walk_err_source_i), .walk_op_done_i(walk_op_done_i),
    .gfx_accept_o(gfx_accept_o), .nb_accept_o(nb_accept_o),
    .burst_count_group_one(burst_count_group_one), .burst_count_group_two(burst_count_group_two),
    .index_set_select_o(index_set_select_o), .debug_select_o(debug_select_o),
    .debug_enable_o(debug_enable_o), .fifo_pop_enable_o(fifo_pop_enable_o),
    .blackout_o(blackout_o), .walker_halt_o(walker_halt_o), .system_error_o(system_error_o),
    .tlb_cache_enable_o(tlb_cache_enable_o), .lookahead_enable_o(lookahead_enable_o),
    .single_level_o(single_level_o), .dir_cache_active_o(dir_cache_active_o),
    .dir_base_o(dir_base_o), .fb_start_o(fb_start_o), .flush_all_o(flush_all_o),
    .entry_flush_o(entry_flush_o), .entry_refresh_o(entry_refresh_o),
    .entry_address_o(entry_address_o));
  mem_clients mem_clients_i (.clk_i(clk_i), .clear_i(clear), .kind_i(kind),
    .gfx_accept_i(gfx_accept_o), .nb_accept_i(nb_accept_o), .req_read_o(rd_q),
    .req_write_o(wr_q), .req_disp_o(dp_q), .gfx_held_o(gfx_held), .nb_held_o(nb_held));
  initial forever #4 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] thr_exp(input logic [1:0] l);
    return 8'h80 - (8'h80 >> l);
  endfunction : thr_exp
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i  <= w;
    adr_i <= ad;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'h1) @(posedge clk_i);
    rdata = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask : wb
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results
  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 20000) begin
      num_errors++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 8'h60, 32'h0);
    chk("misc", `RST_MISC, rdata);
    wb(1'h0, 8'hB4, 32'h0);
    chk("size", `CACHE_SIZE_VAL, rdata);
    wb(1'h0, 8'h04, 32'h0);
    chk("hole", 32'h0, rdata);
    wb(1'h0, 8'h00, 32'h0);
    chk("gen", `RST_GENERAL, rdata);
    chk("acc", 2'h0, {gfx_accept_o, nb_accept_o});
    repeat (4) begin
      r = rnd();
      wb(1'h1, 8'h00, r | 32'h80000000);
      wb(1'h1, 8'h78, r);
      wb(1'h1, 8'hB0, r);
      wb(1'h0, 8'h78, 32'h0);
      chk("fbrd", r & `WMASK_FB, rdata);
      chk("burst", r[7:0], {burst_count_group_two, burst_count_group_one});
      chk("fb", r & `WMASK_FB, fb_start_o);
      chk("dir", {r[11:4], r[31:12], 12'h000}, dir_base_o);
    end
    repeat (3) @(posedge clk_i);
    chk("acc", 2'h3, {gfx_accept_o, nb_accept_o});
    for (int c = 0; c < 12; c++) begin
      lv = c[1:0];
      pin_gfx_level_i <= lv;
      pin_nb_level_i <= lv;
      kind <= (c < 8 || c == 9) ? 3'h1 : (c == 10) ? 3'h4 : 3'h2;
      v = (c < 4) ? {20'h0, 4'h2, lv, 2'h2, lv, 2'h2} : (c < 8) ? 32'h233 :
          (c == 8) ? 32'h0CC : (c == 10) ? 32'h8EE : 32'h4EE;
      wb(1'h1, 8'h98, v);
      repeat (4) @(posedge clk_i);
      clear <= 1'h1;
      @(posedge clk_i);
      clear <= 1'h0;
      repeat (128) @(posedge clk_i);
      @(negedge clk_i);
      a = (c < 8) ? thr_exp(lv) : (c < 10) ? 8'h00 : 8'h70;
      chk("thr", {a, a}, {gfx_held, nb_held});
    end
    for (int b = 0; b < 2; b++) begin
      wb(1'h1, 8'h98, {23'h0, b[0], 8'h00});
      blackout_req_i <= 1'h1;
      n = 0;
      while (blackout_o !== 1'h1 && n < 20) begin
        @(posedge clk_i);
        n++;
      end
      dl[b] = n[7:0];
      blackout_req_i <= 1'h0;
      repeat (8) @(posedge clk_i);
    end
    chk("blk", dl[0] + 8'h01, dl[1]);
    wb(1'h1, 8'h60, 32'h80004000);
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 2; k++) begin
      v = {25'h0, debug_select_o};
      n = 0;
      while (debug_select_o === v[6:0] && n < 40) begin
        @(posedge clk_i);
        n++;
      end
    end
    chk("rot", {v[6:0] + 7'h01, 8'h10}, {debug_select_o, n[7:0]});
    wb(1'h1, 8'h60, 32'h5000);
    enhanced_mode_i <= 1'h1;
    wb(1'h1, 8'h60, 32'h4000);
    repeat (3) @(posedge clk_i);
    v[0] = index_set_select_o;
    enhanced_mode_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk("idx", 2'h2, {v[0], index_set_select_o});
    r = rnd();
    debug_bus_i <= r[31:16];
    wb(1'h1, 8'h7C, r);
    wb(1'h0, 8'h7C, 32'h0);
    chk("dbg", {r[31:16], r[15:0] & 16'hFF1F}, rdata);
    chk("dbgo", {r[15:8], !r[3]}, {debug_enable_o, debug_select_o, fifo_pop_enable_o});
    for (int k = 0; k < 3; k++) begin
      r = (rnd() & 32'hFFFFF000) | ((k == 2) ? 32'h2 : 32'h1);
      a = (k == 0) ? 8'hB8 : 8'hBC;
      wb(1'h1, a, r);
      wb(1'h0, a, 32'h0);
      chk("pend", r[1:0], rdata[1:0]);
      chk("pout", {k == 0, k == 1, k == 2}, {flush_all_o, entry_flush_o, entry_refresh_o});
      walk_op_done_i <= 1'h1;
      @(posedge clk_i);
      walk_op_done_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      wb(1'h1, a, r & 32'hFFFFF000);
      wb(1'h0, a, 32'h0);
      chk("done", 2'h0, rdata[1:0]);
    end
    chk("eadr", r[31:12], entry_address_o);
    for (int h = 0; h < 2; h++) begin
      wb(1'h1, 8'hAC, {20'h0, h[0], 11'h0});
      walk_illegal_i <= 1'h1;
      @(posedge clk_i);
      walk_illegal_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk("halt", h[0], walker_halt_o);
    end
    for (int s = 0; s < 4; s++) begin
      rst_i <= 1'h1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'h0;
      gart_cache_enable_i <= s[0];
      wb(1'h1, 8'hAC, (s < 2) ? 32'hC2050800 : 32'h80010000);
      walk_err_source_i <= s[1:0];
      walk_page_err_i <= 1'h1;
      @(posedge clk_i);
      walk_page_err_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk("cfg", (s < 2) ? 4'hE : {3'h0, s[0]}, {tlb_cache_enable_o, lookahead_enable_o,
          single_level_o, dir_cache_active_o});
      chk("serr", 1'h1, system_error_o);
      wb(1'h0, 8'hAC, 32'h0);
      chk("flag", {s[1:0], 1'h1}, {rdata[29:28], rdata[24]});
    end
    results();
  end
endmodule : memctl_regs_bench
